// ---- rtl/sdmbo_pkg.sv ----
// How it works
// - Base register loads on command, both banks low
// - Stored value held until rewrite, reset or deep power-down
// - Length A0-A2, type A3, latency A4-A6
// - A3 zero sequential, one interleaved
// - Lengths two, four, eight, both types
// - Optional length sixteen, same scheme
// - Length sets columns per read or write
// - Upper column bits select aligned block
// - Burst wraps inside its block
// - Sequential offset is previous plus one
// - One length serves reads and writes
// - Bank one high, zero low loads extended
// - Read latency three, two and four optional
`default_nettype none
package sdmbo_pkg;
    localparam int MODE_W       = 12;
    localparam int COL_W        = 9;
    localparam int BL_LSB       = 0;
    localparam int BL_MSB       = 2;
    localparam int BT_BIT       = 3;
    localparam int CL_LSB       = 4;
    localparam int CL_MSB       = 6;
    localparam logic [2:0] BL_CODE_2  = 3'h1;
    localparam logic [2:0] BL_CODE_4  = 3'h2;
    localparam logic [2:0] BL_CODE_8  = 3'h3;
    localparam logic [2:0] BL_CODE_16 = 3'h4;
    localparam logic [2:0] CL_CODE_2  = 3'h2;
    localparam logic [2:0] CL_CODE_3  = 3'h3;
    localparam logic [2:0] CL_CODE_4  = 3'h4;
    localparam logic [1:0] BANK_BASE  = 2'h0;
    localparam logic [1:0] BANK_EXT   = 2'h2;

    typedef enum logic [1:0] {
        SDMBO_IDLE  = 2'b00,
        SDMBO_BURST = 2'b01
    } sdmbo_state_e;

    typedef struct packed {
        logic                 valid;
        logic                 is_write;
        logic [COL_W-1:0]     col;
    } sdmbo_cmd_s;

    typedef struct packed {
        logic [4:0] len;
        logic       interleave;
        logic [2:0] latency;
        logic       len_ok;
        logic       lat_ok;
    } sdmbo_mode_s;
endpackage
`default_nettype wire

// ---- rtl/sdmbo_decode.sv ----
`default_nettype none
module sdmbo_decode
    import sdmbo_pkg::*;
#(
    parameter bit HAS_BL16 = 1'b1,
    parameter bit HAS_CL2  = 1'b1,
    parameter bit HAS_CL4  = 1'b0
) (
    input  wire logic [MODE_W-1:0] mode_i,
    output sdmbo_mode_s            mode_o
);
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    assign bl_code = mode_i[BL_MSB:BL_LSB];
    assign cl_code = mode_i[CL_MSB:CL_LSB];

    always_comb begin
        mode_o            = '0;
        mode_o.interleave = mode_i[BT_BIT];
        case (bl_code)
            BL_CODE_2:  begin mode_o.len = 5'h02; mode_o.len_ok = 1'b1; end
            BL_CODE_4:  begin mode_o.len = 5'h04; mode_o.len_ok = 1'b1; end
            BL_CODE_8:  begin mode_o.len = 5'h08; mode_o.len_ok = 1'b1; end
            BL_CODE_16: begin mode_o.len = 5'h10; mode_o.len_ok = HAS_BL16; end
            default:    begin mode_o.len = 5'h00; mode_o.len_ok = 1'b0; end
        endcase
        if (!mode_o.len_ok) begin
            mode_o.len = 5'h00;
        end
        case (cl_code)
            CL_CODE_2: begin mode_o.latency = 3'h2; mode_o.lat_ok = HAS_CL2; end
            CL_CODE_3: begin mode_o.latency = 3'h3; mode_o.lat_ok = 1'b1; end
            CL_CODE_4: begin mode_o.latency = 3'h4; mode_o.lat_ok = HAS_CL4; end
            default:   begin mode_o.latency = 3'h0; mode_o.lat_ok = 1'b0; end
        endcase
    end
endmodule
`default_nettype wire

// ---- rtl/sdmbo_burst.sv ----
`default_nettype none
module sdmbo_burst
    import sdmbo_pkg::*;
#(
    parameter bit HAS_BL16 = 1'b1,
    parameter bit HAS_CL2  = 1'b1,
    parameter bit HAS_CL4  = 1'b0
) (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                load_mode_command_i,
    input  wire logic                bank_select_0_i,
    input  wire logic                bank_select_1_i,
    input  wire logic [MODE_W-1:0]   addr_i,
    input  wire logic                deep_power_down_i,
    input  wire sdmbo_pkg::sdmbo_cmd_s cmd_i,
    output logic [MODE_W-1:0]        base_mode_o,
    output logic [MODE_W-1:0]        ext_mode_o,
    output logic                     mode_valid_o,
    output logic [2:0]               read_latency_o,
    output logic                     setting_ok_o,
    output logic                     col_valid_o,
    output logic                     col_write_o,
    output logic                     col_last_o,
    output logic [COL_W-1:0]         col_o
);
    import sdmbo_pkg::*;

    logic [MODE_W-1:0] base_mode_ff;
    logic [MODE_W-1:0] ext_mode_ff;
    logic              mode_valid_ff;
    logic              ext_valid_ff;
    sdmbo_mode_s       mode;
    sdmbo_state_e      state_ff;
    sdmbo_state_e      nxt_state;
    logic [COL_W-1:0]  block_ff;
    logic [3:0]        start_ff;
    logic [3:0]        idx_ff;
    logic [3:0]        mask_ff;
    logic              inter_ff;
    logic              write_ff;
    logic [3:0]        mask_now;
    logic [3:0]        nxt_idx;
    logic              base_load;
    logic              ext_load;
    logic              burst_end;
    logic [3:0]        nxt_offset;
    logic [3:0]        cur_off;
    logic              start_ok;

    assign base_load = load_mode_command_i && !bank_select_1_i && !bank_select_0_i;
    assign ext_load  = load_mode_command_i && bank_select_1_i && !bank_select_0_i;

    // No reset default: contents only become valid when loaded
    always_ff @(posedge clk_i) begin
        if (base_load) begin
            base_mode_ff <= addr_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ext_load) begin
            ext_mode_ff <= addr_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || deep_power_down_i) begin
            mode_valid_ff <= 1'b0;
            ext_valid_ff  <= 1'b0;
        end else begin
            if (base_load) begin
                mode_valid_ff <= 1'b1;
            end
            if (ext_load) begin
                ext_valid_ff <= 1'b1;
            end
        end
    end

    sdmbo_decode #(
        .HAS_BL16 (HAS_BL16),
        .HAS_CL2  (HAS_CL2),
        .HAS_CL4  (HAS_CL4)
    ) u_decode (
        .mode_i (base_mode_ff),
        .mode_o (mode)
    );

    assign mask_now = mode.len_ok ? 4'(mode.len - 5'h01) : 4'h0;
    assign start_ok = cmd_i.valid && mode_valid_ff && mode.len_ok;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SDMBO_IDLE:  if (start_ok && mask_now != 4'h0) nxt_state = SDMBO_BURST;
            SDMBO_BURST: if (burst_end && !start_ok) nxt_state = SDMBO_IDLE;
            default:     nxt_state = SDMBO_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= SDMBO_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign burst_end = (idx_ff == mask_ff);
    assign nxt_idx   = idx_ff + 4'h1;
    // Sequential adds and wraps in the block; interleaved xors the index
    assign nxt_offset = inter_ff ? (start_ff ^ nxt_idx) & mask_ff
                                 : (start_ff + nxt_idx) & mask_ff;
    assign cur_off = (col_o[3:0] & mask_ff);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idx_ff      <= 4'h0;
            mask_ff     <= 4'h0;
            start_ff    <= 4'h0;
            inter_ff    <= 1'b0;
            write_ff    <= 1'b0;
            block_ff    <= '0;
            col_o       <= '0;
            col_valid_o <= 1'b0;
            col_last_o  <= 1'b0;
            col_write_o <= 1'b0;
        end else if (start_ok) begin
            // A new command cuts off a running burst
            idx_ff      <= 4'h0;
            mask_ff     <= mask_now;
            start_ff    <= cmd_i.col[3:0] & mask_now;
            inter_ff    <= mode.interleave;
            write_ff    <= cmd_i.is_write;
            block_ff    <= cmd_i.col & ~COL_W'(mask_now);
            col_o       <= cmd_i.col;
            col_valid_o <= 1'b1;
            col_last_o  <= (mask_now == 4'h0);
            col_write_o <= cmd_i.is_write;
        end else if (state_ff == SDMBO_BURST && !burst_end) begin
            idx_ff      <= nxt_idx;
            col_o       <= block_ff | COL_W'(nxt_offset);
            col_valid_o <= 1'b1;
            col_last_o  <= (nxt_idx == mask_ff);
            col_write_o <= write_ff;
        end else begin
            col_valid_o <= 1'b0;
            col_last_o  <= 1'b0;
        end
    end

    assign base_mode_o    = mode_valid_ff ? base_mode_ff : '0;
    assign ext_mode_o     = ext_valid_ff ? ext_mode_ff : '0;
    assign mode_valid_o   = mode_valid_ff && ext_valid_ff;
    assign read_latency_o = (mode_valid_ff && mode.lat_ok) ? mode.latency : 3'h0;
    assign setting_ok_o   = mode_valid_ff && mode.len_ok && mode.lat_ok;

    // A new command may cut the burst and pick another block, so it is excluded
    property p_block_kept;
        @(posedge clk_i) disable iff (sys_rst_i)
        col_valid_o && !col_last_o && !start_ok |=> col_valid_o
            && ((col_o & ~COL_W'(mask_ff)) == ($past(col_o) & ~COL_W'(mask_ff)));
    endproperty
    a_block_kept: assert property (p_block_kept) else $error("burst left block");

    property p_seq_step;
        @(posedge clk_i) disable iff (sys_rst_i)
        col_valid_o && !col_last_o && !inter_ff && !start_ok |=>
            cur_off == (($past(cur_off) + 4'h1) & mask_ff);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");

    property p_int_step;
        @(posedge clk_i) disable iff (sys_rst_i)
        col_valid_o && inter_ff && idx_ff != 4'h0 |-> cur_off == ((start_ff ^ idx_ff) & mask_ff);
    endproperty
    a_int_step: assert property (p_int_step) else $error("interleaved order wrong");

    sequence s_len_burst;
        col_valid_o [*2];
    endsequence
    property p_len_min;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(col_valid_o) |-> s_len_burst;
    endproperty
    a_len_min: assert property (p_len_min) else $error("burst shorter than two");

    property p_last_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        col_last_o && !start_ok |=> !col_valid_o;
    endproperty
    a_last_end: assert property (p_last_end) else $error("burst ran past last column");
    property p_len2;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(col_valid_o) && mask_ff == 4'h1 && !start_ok ##1 !start_ok
            |-> col_last_o ##1 !col_valid_o;
    endproperty
    a_len2: assert property (p_len2) else $error("burst of two wrong length");

    property p_base_load;
        @(posedge clk_i) disable iff (sys_rst_i)
        base_load && !deep_power_down_i |=> base_mode_o == $past(addr_i);
    endproperty
    a_base_load: assert property (p_base_load) else $error("base setting not loaded");

    property p_ext_only;
        @(posedge clk_i) disable iff (sys_rst_i)
        ext_load && !base_load && mode_valid_ff && !deep_power_down_i |=> $stable(base_mode_o);
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("extended load hit base");

    property p_dpd;
        @(posedge clk_i) disable iff (sys_rst_i)
        deep_power_down_i |=> !mode_valid_o && read_latency_o == 3'h0;
    endproperty
    a_dpd: assert property (p_dpd) else $error("setting kept after power-down");

    property p_lat3;
        @(posedge clk_i) disable iff (sys_rst_i)
        base_load && !deep_power_down_i && addr_i[CL_MSB:CL_LSB] == CL_CODE_3
            |=> read_latency_o == 3'h3;
    endproperty
    a_lat3: assert property (p_lat3) else $error("latency three not decoded");
endmodule
`default_nettype wire

// ---- sim/sdmbo_ctrl_model.sv ----
`default_nettype none
module sdmbo_ctrl_model
    import sdmbo_pkg::*;
(
    input  wire logic             clk_i,
    output logic                  load_o,
    output logic                  bank_select_0_o,
    output logic                  bank_select_1_o,
    output logic [MODE_W-1:0]     addr_o,
    output sdmbo_pkg::sdmbo_cmd_s cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MODE_WAIT = 2;
    initial begin
        load_o = 1'h0;
        {bank_select_1_o, bank_select_0_o} = 2'h0;
        addr_o = '0;
        cmd_o = '0;
    end
    // Callers load only once the previous burst has ended
    task automatic load(input logic [1:0] bank, input logic [6:0] val);
        @(posedge clk_i);
        load_o <= 1'h1;
        {bank_select_1_o, bank_select_0_o} <= bank;
        addr_o <= {5'h00, val}; // Undefined bits low
        @(posedge clk_i);
        load_o <= 1'h0;
        addr_o <= ~addr_o; // Released bus shows garbage, not the old value
        repeat (MODE_WAIT) @(posedge clk_i);
    endtask
    task automatic burst(input logic wr, input logic [COL_W-1:0] col);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'h1, is_write: wr, col: col};
        @(posedge clk_i);
        cmd_o <= '{valid: 1'h0, is_write: ~wr, col: ~col};
    endtask
endmodule
`default_nettype wire

// ---- sim/sdram_mode_and_burst_order_tb.sv ----
`default_nettype none
module sdram_mode_and_burst_order_tb
    import sdmbo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i = 1'h0;
    logic              sys_rst_i = 1'h1;
    logic              dpd = 1'h0;
    logic              ld, b0, b1, mv, sok, cv, cw, cl;
    logic [MODE_W-1:0] ad, bm, em, prev;
    logic [2:0]        rl;
    logic [COL_W-1:0]  co;
    sdmbo_cmd_s        cmd;
    int                errors = 0, n_tests = 0, cyc = 0, seed = 99058;

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc == 5000) begin
        errors++;
        conclude();
    end

    sdmbo_ctrl_model u_ctrl (.clk_i(clk_i), .load_o(ld), .bank_select_0_o(b0),
        .bank_select_1_o(b1), .addr_o(ad), .cmd_o(cmd));
    sdmbo_burst dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .load_mode_command_i(ld),
        .bank_select_0_i(b0), .bank_select_1_i(b1), .addr_i(ad), .deep_power_down_i(dpd),
        .cmd_i(cmd), .base_mode_o(bm), .ext_mode_o(em), .mode_valid_o(mv),
        .read_latency_o(rl), .setting_ok_o(sok), .col_valid_o(cv), .col_write_o(cw),
        .col_last_o(cl), .col_o(co));

    task automatic conclude();
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'h1) begin
            errors++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    // Block bits kept, in-block offset stepped or flipped
    function automatic logic [COL_W-1:0] exp_col(input logic [COL_W-1:0] c, input int len,
                                                 input logic il, input int k);
        logic [COL_W-1:0] m;
        m = COL_W'(len - 1);
        return (c & ~m) | ((il ? (c ^ COL_W'(k)) : (c + COL_W'(k))) & m);
    endfunction
    task automatic run(input logic [2:0] blc, input logic bt, input logic [2:0] clc,
                       input logic [COL_W-1:0] c, input logic wr);
        int len;
        len = 1 << blc;
        u_ctrl.load(BANK_BASE, {clc, bt, blc});
        chk(bm === {5'h00, clc, bt, blc}, "base setting");
        chk(rl === ((clc == CL_CODE_2) ? 3'h2 : 3'h3), "latency");
        chk(sok === 1'h1, "setting refused");
        u_ctrl.burst(wr, c);
        for (int k = 0; k < len; k++) begin
            #1;
            chk(cv === 1'h1 && cw === wr, "column strobe");
            chk(co === exp_col(c, len, bt, k), "column");
            chk(cl === (k == len - 1), "last flag");
            @(posedge clk_i);
        end
        #1 chk(cv === 1'h0, "burst overrun");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        u_ctrl.load(BANK_EXT, 7'h20);
        chk(em === 12'h020, "extended setting");
        run(BL_CODE_8, 1'h0, CL_CODE_3, 9'h005, 1'h0);
        chk(mv === 1'h1, "settings valid");
        for (int i = 0; i < 24; i++)
            run(3'(1 + i % 4), 1'(i / 4), ($random(seed) & 1) ? CL_CODE_2 : CL_CODE_3,
                9'($random(seed)), 1'($random(seed)));
        prev = bm;
        u_ctrl.load(2'h1, 7'h7F);
        u_ctrl.load(2'h3, 7'h7F);
        chk(bm === prev, "reserved bank loaded");
        u_ctrl.load(BANK_EXT, 7'h05);
        chk(bm === prev && em === 12'h005, "extended load");
        u_ctrl.load(BANK_BASE, 7'h30);
        chk(sok === 1'h0, "reserved length accepted");
        u_ctrl.burst(1'h0, 9'h000);
        repeat (4) begin
            #1 chk(cv === 1'h0, "burst on reserved length");
            @(posedge clk_i);
        end
        u_ctrl.load(BANK_BASE, 7'h43);
        chk(rl === 3'h0 && sok === 1'h0, "reserved latency accepted");
        dpd <= 1'h1;
        @(posedge clk_i);
        dpd <= 1'h0;
        @(posedge clk_i);
        #1 chk(mv === 1'h0 && bm === 12'h000 && rl === 3'h0, "kept after power-down");
        conclude();
    end
endmodule
`default_nettype wire
